// *** verilog/gpeio_defines.vh ***
`ifndef GPEIO_DEFINES_VH
`define GPEIO_DEFINES_VH

// Configuration offsets, function 0 only
`define GPEIO_OFS_STATUS      8'hA8
`define GPEIO_OFS_ENABLE      8'hAA
`define GPEIO_OFS_INPUT       8'hAC
`define GPEIO_OFS_OUTPUT      8'hAE
`define GPEIO_OWN_FUNC        3'h0

// Bit positions shared by status and enable
`define GPEIO_BIT_ZV0         15
`define GPEIO_BIT_ZV1         14
`define GPEIO_BIT_PWR         11
`define GPEIO_BIT_VPP12       8

// Writable masks
`define GPEIO_EVT_MASK        16'hC91F
`define GPEIO_PIN_MASK        16'h001F

// Reset values
`define GPEIO_ENABLE_RST      16'h0000
`define GPEIO_STATUS_RST      16'h0000
`define GPEIO_OUTPUT_RST      5'h00

`endif

// *** verilog/gpeio_sync.v ***
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser with a change pulse taken from the settled copy
module gpeio_sync #(
    parameter WIDTH = 5
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] level_q,
    output wire [WIDTH-1:0] change
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] prev_q;
    reg [2:0]       arm_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= {WIDTH{1'b0}};
            level_q  <= {WIDTH{1'b0}};
            prev_q   <= {WIDTH{1'b0}};
            arm_q    <= 3'h0;
        end else begin
            meta_q   <= async_in;
            level_q  <= meta_q;
            prev_q   <= level_q;
            arm_q    <= {arm_q[1:0], 1'b1};
        end
    end

    // No change reported until prev_q holds a real sample, three edges after reset
    assign change = arm_q[2] ? (level_q ^ prev_q) : {WIDTH{1'b0}};
endmodule

`default_nettype wire

// *** verilog/gpeio_top.v ***
`timescale 1ns/1ns
`default_nettype none
`include "gpeio_defines.vh"

module gpeio_top #(
    parameter NPINS = 5
) (
    input  wire             SYS_CLK,
    input  wire             RST_N,
    input  wire [2:0]       CFG_FUNC,
    input  wire [7:0]       CFG_ADDR,
    input  wire [1:0]       CFG_BE,
    input  wire             CFG_WR,
    input  wire             CFG_RD,
    input  wire [15:0]      CFG_WDATA,
    output reg  [15:0]      CFG_RDATA,
    output reg              CFG_RVALID,
    input  wire             SOCKET0_VIDEO_PORT_ON,
    input  wire             SOCKET1_VIDEO_PORT_ON,
    input  wire             SOCKET_POWER_WRITE,
    input  wire             PROG_VOLTAGE_12V_CHANGE,
    input  wire             EVENT_PIN_SELECTED,
    input  wire [NPINS-1:0] PIN_IS_INPUT,
    input  wire [NPINS-1:0] PIN_IS_OUTPUT,
    input  wire [NPINS-1:0] MULTIFUNCTION_PINS_IN,
    output wire [NPINS-1:0] MULTIFUNCTION_PINS_OUT,
    output wire [NPINS-1:0] MULTIFUNCTION_PINS_OE,
    output wire             GENERAL_EVENT_SIGNAL
);
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reset release
    reg rst_meta_q;
    reg rst_sync_q;
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Access decode
    function [15:0] gpeio_lane_mask;
        input [1:0] be;
        begin
            gpeio_lane_mask = {{8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // Only function 0 answers; the other socket's function sees nothing here
    function gpeio_hit;
        input [2:0] func;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            gpeio_hit = (func == `GPEIO_OWN_FUNC) && (addr == ofs);
        end
    endfunction

    // Byte lanes left disabled keep their old contents
    function [15:0] gpeio_merge;
        input [15:0] old;
        input [15:0] wdata;
        input [15:0] lanes;
        begin
            gpeio_merge = (wdata & lanes) | (old & ~lanes);
        end
    endfunction

    // Pin registers carry NPINS live bits; the rest read zero
    function [15:0] gpeio_pad;
        input [NPINS-1:0] bits;
        begin
            gpeio_pad = {{(16-NPINS){1'b0}}, bits};
        end
    endfunction

    wire        own_func = (CFG_FUNC == `GPEIO_OWN_FUNC);
    wire [15:0] lanes    = gpeio_lane_mask(CFG_BE);
    wire        wr_sts   = CFG_WR & gpeio_hit(CFG_FUNC, CFG_ADDR, `GPEIO_OFS_STATUS);
    wire        wr_en    = CFG_WR & gpeio_hit(CFG_FUNC, CFG_ADDR, `GPEIO_OFS_ENABLE);
    wire        wr_out   = CFG_WR & gpeio_hit(CFG_FUNC, CFG_ADDR, `GPEIO_OFS_OUTPUT);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin sampling
    wire [NPINS-1:0] pin_level;
    wire [NPINS-1:0] pin_change;
    gpeio_sync #(.WIDTH(NPINS)) u_pin_sync (
        .clk      (SYS_CLK),
        .rst_n    (rst_n),
        .async_in (MULTIFUNCTION_PINS_IN),
        .level_q  (pin_level),
        .change   (pin_change)
    );

    // Video-port-on levels come from on-chip logic, already in this clock domain
    reg zv0_prev_q;
    reg zv1_prev_q;
    reg zv_primed_q;
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            zv0_prev_q  <= 1'b0;
            zv1_prev_q  <= 1'b0;
            zv_primed_q <= 1'b0;
        end else begin
            zv0_prev_q  <= SOCKET0_VIDEO_PORT_ON;
            zv1_prev_q  <= SOCKET1_VIDEO_PORT_ON;
            zv_primed_q <= 1'b1;
        end
    end

    // One-cycle change pulses, ready for the status merge below
    wire             zv0_change = zv_primed_q & (SOCKET0_VIDEO_PORT_ON ^ zv0_prev_q);
    wire             zv1_change = zv_primed_q & (SOCKET1_VIDEO_PORT_ON ^ zv1_prev_q);
    // Only pins set as general inputs report level changes
    wire [NPINS-1:0] pin_event  = pin_change & PIN_IS_INPUT;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Event status and enable
    reg  [15:0] status_q;
    reg  [15:0] enable_q;
    reg  [15:0] events;
    reg  [15:0] status_d;

    // Write-one-to-clear, honouring the byte lanes of the access
    wire [15:0] sts_clear = wr_sts ? gpeio_merge(16'h0000, CFG_WDATA, lanes) : 16'h0000;

    always @* begin
        events = 16'h0000;
        events[`GPEIO_BIT_ZV0]   = zv0_change;
        events[`GPEIO_BIT_ZV1]   = zv1_change;
        events[`GPEIO_BIT_PWR]   = SOCKET_POWER_WRITE;
        events[`GPEIO_BIT_VPP12] = PROG_VOLTAGE_12V_CHANGE;
        events[NPINS-1:0]        = pin_event;
        // A new event in the clearing cycle wins over the clear
        status_d = (status_q & ~sts_clear) | events;
        status_d = status_d & `GPEIO_EVT_MASK;
    end

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= `GPEIO_STATUS_RST;
            enable_q <= `GPEIO_ENABLE_RST;
        end else begin
            status_q <= status_d;
            if (wr_en) begin
                enable_q <= gpeio_merge(enable_q, CFG_WDATA, lanes) & `GPEIO_EVT_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Event output
    // Kept combinational so the event drops in the cycle the clear lands
    // Event held by status until software clears it
    wire event_raw = |(status_q & enable_q);
    assign GENERAL_EVENT_SIGNAL = event_raw & EVENT_PIN_SELECTED;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Output value register
    reg  [NPINS-1:0] out_q;
    wire [15:0]      out_merged = gpeio_merge(gpeio_pad(out_q), CFG_WDATA, lanes);
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= `GPEIO_OUTPUT_RST;
        end else if (wr_out) begin
            // Upper bits are reserved and never stored
            out_q <= out_merged[NPINS-1:0];
        end
    end
    assign MULTIFUNCTION_PINS_OUT = out_q;
    assign MULTIFUNCTION_PINS_OE  = PIN_IS_OUTPUT;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Read path, registered; unmapped offsets and other functions read zero
    reg [15:0] rd_d;
    always @* begin
        rd_d = 16'h0000;
        if (own_func) begin
            case (CFG_ADDR)
                `GPEIO_OFS_STATUS: rd_d = status_q;
                `GPEIO_OFS_ENABLE: rd_d = enable_q;
                // Input writes fall through to no register at all
                `GPEIO_OFS_INPUT:  rd_d = gpeio_pad(pin_level);
                `GPEIO_OFS_OUTPUT: rd_d = gpeio_pad(out_q);
                default:           rd_d = 16'h0000;
            endcase
        end
    end

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            CFG_RDATA  <= 16'h0000;
            CFG_RVALID <= 1'b0;
        end else begin
            CFG_RVALID <= CFG_RD;
            if (CFG_RD) begin
                CFG_RDATA <= rd_d;
            end
        end
    end
endmodule

`default_nettype wire

// *** verif/gpeio_chk_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module gpeio_chk #(parameter NPINS = 5) (
    input wire logic             SYS_CLK,
    input wire logic             RST_N,
    input wire logic [2:0]       CFG_FUNC,
    input wire logic [7:0]       CFG_ADDR,
    input wire logic [1:0]       CFG_BE,
    input wire logic             CFG_WR,
    input wire logic             CFG_RD,
    input wire logic [15:0]      CFG_WDATA,
    input wire logic [15:0]      CFG_RDATA,
    input wire logic             CFG_RVALID,
    input wire logic             EVENT_PIN_SELECTED,
    input wire logic [NPINS-1:0] PIN_IS_OUTPUT,
    input wire logic [NPINS-1:0] MULTIFUNCTION_PINS_OUT,
    input wire logic [NPINS-1:0] MULTIFUNCTION_PINS_OE,
    input wire logic             GENERAL_EVENT_SIGNAL
);
    wire f0 = CFG_FUNC == 3'h0;
    wire wo = CFG_WR && f0 && CFG_ADDR == 8'hAE && CFG_BE[0];
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    AST_FUNC: assert property (CFG_RD && !f0 |=> CFG_RVALID && CFG_RDATA == 16'h0000)
        else $error("other function answered");
    AST_RVAL: assert property (!CFG_RD |=> !CFG_RVALID)
        else $error("read valid without read");
    AST_ENRSV: assert property (CFG_RD && f0 && CFG_ADDR == 8'hAA
        |=> (CFG_RDATA & 16'h36E0) == 16'h0000)
        else $error("enable reserved bits set");
    AST_PINRSV: assert property (CFG_RD && f0 && CFG_ADDR[7:2] == 6'h2B
        |=> CFG_RDATA[15:5] == 11'h000)
        else $error("pin register upper bits set");
    AST_OE: assert property (MULTIFUNCTION_PINS_OE == PIN_IS_OUTPUT)
        else $error("output enable wrong");
    AST_GATE: assert property (!EVENT_PIN_SELECTED |-> !GENERAL_EVENT_SIGNAL)
        else $error("event without event pin");
    AST_HOLD: assert property (GENERAL_EVENT_SIGNAL && !CFG_WR
        |=> GENERAL_EVENT_SIGNAL || !EVENT_PIN_SELECTED)
        else $error("event dropped without write");
    AST_OUTW: assert property (wo |=> MULTIFUNCTION_PINS_OUT == $past(CFG_WDATA[4:0]))
        else $error("pin output not written");
    AST_RB: assert property (wo ##1 CFG_RD && f0 && CFG_ADDR == 8'hAE && !CFG_WR
        |=> CFG_RDATA[4:0] == $past(CFG_WDATA[4:0], 2)) else $error("output readback wrong");
endmodule
bind gpeio_top gpeio_chk #(.NPINS(NPINS)) gpeio_chk_inst (.*);
`default_nettype wire

// *** verif/gpeio_pm_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Wake logic: counts event rises; a level stuck high counts once only
module gpeio_pm_model (
    input  wire logic       clk,
    input  wire logic       event_in,
    output wire logic [7:0] wake_count
);
    logic       seen_q = 1'b0;
    logic [7:0] count_q = 8'h00;
    always @(posedge clk) begin
        seen_q <= event_in;
        if (event_in && !seen_q) count_q <= count_q + 8'h01;
    end
    assign wake_count = count_q;
endmodule
`default_nettype wire

// *** verif/gpeio_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module gpeio_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, zv0 = 1'b0, zv1 = 1'b0;
    logic pwr = 1'b0, vpp = 1'b0, sel = 1'b1;
    logic [2:0] func = 3'h0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic [4:0] pins = 5'h0A;
    logic [4:0] pin_in = 5'h1F;
    logic [1:0] be = 2'h3;
    wire [15:0] rdat;
    wire rv, evt;
    wire [4:0] pout, poe;
    wire [7:0] wakes;
    int err_count = 0, cmp_count = 0;
    always #5 clk = ~clk;
    gpeio_top gpeio_top_inst (.SYS_CLK(clk), .RST_N(rst_n), .CFG_FUNC(func), .CFG_ADDR(addr),
        .CFG_BE(be), .CFG_WR(wr), .CFG_RD(rd), .CFG_WDATA(wd), .CFG_RDATA(rdat), .CFG_RVALID(rv),
        .SOCKET0_VIDEO_PORT_ON(zv0), .SOCKET1_VIDEO_PORT_ON(zv1), .SOCKET_POWER_WRITE(pwr),
        .PROG_VOLTAGE_12V_CHANGE(vpp), .EVENT_PIN_SELECTED(sel), .PIN_IS_INPUT(pin_in),
        .PIN_IS_OUTPUT(5'h15), .MULTIFUNCTION_PINS_IN(pins), .MULTIFUNCTION_PINS_OUT(pout),
        .MULTIFUNCTION_PINS_OE(poe), .GENERAL_EVENT_SIGNAL(evt));
    gpeio_pm_model gpeio_pm_model_inst (.clk(clk), .event_in(evt), .wake_count(wakes));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= w; rd <= !w; addr <= a; wd <= d;
        @(posedge clk);
        wr <= 1'b0; rd <= 1'b0;
        #1 chk({15'h0, rv}, {15'h0, !w});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk(rdat, e);
    endtask
    task automatic t_regs;
        rdc(8'hAA, 16'h0000);
        rdc(8'hAE, 16'h0000);
        acc(1'b1, 8'hAA, 16'hFFFF);
        rdc(8'hAA, 16'hC91F);
        acc(1'b1, 8'hAC, 16'hFFFF);
        rdc(8'hAC, 16'h000A);
        acc(1'b1, 8'hAE, 16'hFFFF);
        rdc(8'hAE, 16'h001F);
        chk({11'h0, pout}, 16'h001F);
        chk({11'h0, poe}, 16'h0015);
    endtask
    task automatic t_func;
        @(posedge clk) func <= 3'h1;
        acc(1'b1, 8'hAA, 16'h0000);
        rdc(8'hAA, 16'h0000);
        @(posedge clk) func <= 3'h0;
        rdc(8'hAA, 16'hC91F);
    endtask
    task automatic t_events;
        int b, n;
        for (int i = 0; i < 9; i++) begin
            b = i == 0 ? 15 : i == 1 ? 14 : i == 2 ? 11 : i == 3 ? 8 : i - 4;
            @(posedge clk);
            if (i == 0) zv0 <= ~zv0;
            if (i == 1) zv1 <= ~zv1;
            pwr <= i == 2;
            vpp <= i == 3;
            if (i > 3) pins[i-4] <= ~pins[i-4];
            @(posedge clk) {pwr, vpp} <= 2'h0;
            n = 0;
            while (evt !== 1'b1 && n < 12) begin @(posedge clk); n++; end
            chk({15'h0, evt}, 16'h0001);
            if (n == 12) summarize();
            rdc(8'hA8, 16'h0001 << b);
            @(posedge clk) sel <= 1'b0;
            #1 chk({15'h0, evt}, 16'h0000);
            @(posedge clk) sel <= 1'b1;
            acc(1'b1, 8'hA8, 16'h0001 << b);
            chk({15'h0, evt}, 16'h0000);
        end
    endtask
    task automatic t_noen;
        acc(1'b1, 8'hAA, 16'h0000);
        @(posedge clk) pwr <= 1'b1;
        @(posedge clk) pwr <= 1'b0;
        rdc(8'hA8, 16'h0800);
        chk({15'h0, evt}, 16'h0000);
        acc(1'b1, 8'hA8, 16'h0800);
        rdc(8'hA8, 16'h0000);
        chk({8'h0, wakes}, 16'h0012);
    endtask
    task automatic t_lanes;
        @(posedge clk) be <= 2'h1;
        acc(1'b1, 8'hAA, 16'hFFFF);
        rdc(8'hAA, 16'h001F);
        @(posedge clk) be <= 2'h2;
        acc(1'b1, 8'hAA, 16'hFFFF);
        rdc(8'hAA, 16'hC91F);
        @(posedge clk) be <= 2'h0;
        acc(1'b1, 8'hAA, 16'h0000);
        rdc(8'hAA, 16'hC91F);
        @(posedge clk) be <= 2'h3;
        acc(1'b1, 8'hAA, 16'h0000);
        rdc(8'hAA, 16'h0000);
    endtask
    task automatic t_pin_cfg;
        @(posedge clk) pin_in <= 5'h1E;
        @(posedge clk) pins[0] <= ~pins[0];
        repeat (4) @(posedge clk);
        rdc(8'hA8, 16'h0000);
        @(posedge clk) pin_in <= 5'h1F;
        @(posedge clk) pins[0] <= ~pins[0];
        repeat (4) @(posedge clk);
        rdc(8'hA8, 16'h0001);
        rdc(8'hAC, {11'h000, pins});
        acc(1'b1, 8'hA8, 16'h0001);
        rdc(8'hA8, 16'h0000);
    endtask
    task automatic t_b2b;
        @(posedge clk);
        wr <= 1'b1;
        addr <= 8'hAE;
        wd <= 16'h0015;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({15'h0, rv}, 16'h0001);
        chk(rdat, 16'h0015);
        chk({11'h0, pout}, 16'h0015);
    endtask
    task automatic t_reset;
        acc(1'b1, 8'hAA, 16'hFFFF);
        acc(1'b1, 8'hAE, 16'h001F);
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(8'hAA, 16'h0000);
        rdc(8'hAE, 16'h0000);
        rdc(8'hA8, 16'h0000);
        chk({11'h0, pout}, 16'h0000);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_func();
        t_events();
        t_noen();
        t_lanes();
        t_pin_cfg();
        t_b2b();
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire
